/* File: include/sdram_slice_pkg.sv */
/*
  package for the sdram protocol slice: command codes, burst modes, self-refresh
  states, exit delay counts, reset values and the write beat carrier.
  assumes a single 100 MHz core clock that samples every memory pin.
*/
package sdram_slice_pkg;
  // burst-length field of the burst mode register
  localparam logic [1:0] BL_FIXED_FULL = 2'h0;  // always eight beats
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;  // chosen per command
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;  // always four beats
  // address bit positions with a special meaning
  localparam int CHOP_SELECT_BIT = 12;
  localparam int PRECHARGE_ALL_BIT = 10;
  // beats per burst
  localparam logic [3:0] CHOP_BEATS = 4'h4;
  localparam logic [3:0] FULL_BEATS = 4'h8;
  // exit delays, counted in link clock rising edges
  localparam logic [9:0] SELF_REFRESH_EXIT_CYCLES = 10'h010;
  localparam logic [9:0] LOCKED_LOOP_EXIT_CYCLES = 10'h200;
  // values after reset
  localparam logic [7:0] BANKS_RST = 8'h00;
  localparam logic [9:0] EXIT_CNT_RST = 10'h000;
  localparam logic [3:0] BEATS_RST = 4'h0;
  // write fifo shape
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_CNT_RST = 3'h0;
  // command code as {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000, CMD_REFRESH = 3'b001, CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE = 3'b011, CMD_WRITE = 3'b100, CMD_READ = 3'b101,
    CMD_CALIBRATE = 3'b110, CMD_NOP = 3'b111
  } cmd_e;
  // self-refresh state
  typedef enum logic [1:0] {
    SR_RUN = 2'b00, SR_HOLD = 2'b01, SR_EXIT = 2'b10
  } sr_state_e;
  // one captured write beat
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  mask;
  } wr_beat_s;
  // every pin the slice samples
  typedef struct packed {
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic [2:0]  cmd;
    logic [14:0] addr;
    logic [2:0]  ba;
    logic        strobe;
    wr_beat_s    beat;
  } pin_s;
endpackage

/* File: design/sdram_slice.sv */
/*
  sdram protocol slice inside the memory device: command decode on the
  sampled command clock, burst chop selection, bank precharge, self-refresh
  entry and exit with delay-loop control, and strobe-edge write capture into a
  small fifo.
  assumes every memory pin is asynchronous to ref_clk_i and toggles slowly
  enough (command clock 125 ns) that 100 MHz sampling sees each level.
*/
// Function
// R1 - controller waits write-to-read delay after data
// R2 - burst field 10 forces four-beat chop
// R3 - field 01 with chop bit low chops
// R4 - data captured on strobe crossings, not clock
// R5 - controller drives write preamble on strobe
// R6 - controller holds strobe low for postamble
// R7 - precharge-all bit picks one or all banks
// R8 - precharged bank idle until activated again
// R9 - refresh with enable low enters self refresh
// R10 - loop off on entry, reset on exit
// R11 - first write 512 clocks after reference valid
// R12 - all banks precharged before self-refresh entry
// R13 - termination low before self-refresh entry
// R14 - stay in self refresh, ignore other inputs
// R15 - one internal refresh right at entry
// R16 - controller sends no-op after entry command
// R17 - controller respects minimum low and clock times
// R18 - only no-ops during exit delay
// R19 - calibration before commands needing locked loop
// R20 - exit delays count from first enable-high edge
// R21 - controller doubles refresh above 85 degrees
// R22 - self refresh above 85 needs temperature option
// R23 - automatic and extended bits never both set
// R24 - controller keeps timings as cycle counts

// fifo: shift register so the head is always a flip-flop
module beat_fifo
  import sdram_slice_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  logic [WIDTH-1:0] mem_ff [DEPTH];   // entry 0 is the head
  logic [2:0]       cnt_ff;           // words held
  logic [2:0]       nxt_cnt;
  wire              push_w = in_valid_i & in_ready_o;
  wire              pop_w = out_valid_o & out_ready_i;
  // one-hot-free count update, push and pop may coincide
  assign nxt_cnt = cnt_ff + {2'b00, push_w} - {2'b00, pop_w};
  // ready and valid track the count in flops, so outputs stay registered
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= FIFO_CNT_RST;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      in_ready_o <= (nxt_cnt != 3'(DEPTH));
      out_valid_o <= (nxt_cnt != 3'h0);
    end
  end
  // each slot shifts toward the head on pop and loads at the tail on push
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    wire [2:0] tail_w = pop_w ? cnt_ff - 3'h1 : cnt_ff;
    wire [WIDTH-1:0] next_w = (i == DEPTH - 1) ? mem_ff[i] : mem_ff[(i + 1) % DEPTH];
    always_ff @(posedge ref_clk_i) begin
      if (push_w && tail_w == 3'(i)) begin
        mem_ff[i] <= in_data_i;
      end else if (pop_w) begin
        mem_ff[i] <= next_w;
      end
    end
  end
  assign out_data_o = mem_ff[0];
endmodule

module sdram_slice
  import sdram_slice_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cmd_clock_i,           // sampled command clock
  input  wire logic        clock_enable_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        row_strobe_n_i,
  input  wire logic        col_strobe_n_i,
  input  wire logic        write_enable_n_i,
  input  wire logic [14:0] address_i,
  input  wire logic [2:0]  bank_i,
  input  wire logic [1:0]  burst_mode_i,          // burst mode register field
  input  wire logic        data_strobe_true_i,
  input  wire logic [31:0] data_i,
  input  wire logic [3:0]  data_mask_i,
  input  wire logic        beat_ready_i,
  output logic [7:0]       bank_open_o,
  output logic             burst_chop_o,
  output logic             self_refresh_o,
  output logic             dll_enable_o,
  output logic             dll_reset_o,
  output logic             internal_refresh_o,
  output logic             exit_ready_o,
  output logic             dll_ready_o,
  output logic             idle_access_err_o,
  output logic             wr_overrun_o,
  output wr_beat_s         beat_o,
  output logic             beat_valid_o
);
  pin_s       pin_raw;                    // pins gathered
  pin_s       meta_ff;                    // first sync stage
  pin_s       pin_ff;                     // second sync stage, safe to read
  logic       ck_prev_ff;                 // last sampled clock level
  logic       strobe_prev_ff;             // last sampled strobe level
  logic [1:0] mode_meta_ff;               // mode field, first stage
  logic [1:0] mode_ff;                    // mode field, second stage
  sr_state_e  sr_ff;                      // self-refresh state
  sr_state_e  nxt_sr;
  logic [9:0] exit_cnt_ff;                // edges since exit began
  logic       wr_armed_ff;                // write seen, waiting for data
  logic [3:0] beats_left_ff;              // beats still to capture
  logic       fifo_ready;

  assign pin_raw = '{ck: cmd_clock_i, cke: clock_enable_i, cs_n: chip_select_n_i,
                     cmd: {row_strobe_n_i, col_strobe_n_i, write_enable_n_i},
                     addr: address_i, ba: bank_i, strobe: data_strobe_true_i,
                     beat: '{data: data_i, mask: data_mask_i}};

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge ref_clk_i) begin
    meta_ff <= pin_raw;
    pin_ff <= meta_ff;
    mode_meta_ff <= burst_mode_i;
    mode_ff <= mode_meta_ff;
  end

  // edge finders on the synchronised clock and strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ck_prev_ff <= 1'b0;
      strobe_prev_ff <= 1'b1;   // idle strobe is high, so no false edge
    end else begin
      ck_prev_ff <= pin_ff.ck;
      strobe_prev_ff <= pin_ff.strobe;
    end
  end

  // command decode, taken on the sampled clock's rising edge
  wire  ck_rise_w = pin_ff.ck & ~ck_prev_ff;
  wire  strobe_edge_w = pin_ff.strobe ^ strobe_prev_ff;
  wire  strobe_rise_w = pin_ff.strobe & ~strobe_prev_ff;
  cmd_e cmd_w;
  assign cmd_w = pin_ff.cs_n ? CMD_NOP : cmd_e'(pin_ff.cmd);
  // commands only count outside self refresh, or once the exit delay is over
  // R14 inputs ignored
  wire  live_w = (sr_ff == SR_RUN) || (sr_ff == SR_EXIT && exit_ready_o);
  wire  take_w = ck_rise_w & live_w;
  wire  is_act_w = take_w & (cmd_w == CMD_ACTIVATE);
  wire  is_pre_w = take_w & (cmd_w == CMD_PRECHARGE);
  wire  is_rw_w = take_w & (cmd_w == CMD_READ || cmd_w == CMD_WRITE);
  wire  is_wr_w = take_w & (cmd_w == CMD_WRITE);
  // R9 refresh with enable low
  wire  sr_entry_w = take_w & (cmd_w == CMD_REFRESH) & ~pin_ff.cke;
  // R20 first edge with enable high
  wire  sr_exit_w = ck_rise_w & (sr_ff == SR_HOLD) & pin_ff.cke;

  // R2 fixed chop
  wire  fixed_chop_w = (mode_ff == BL_FIXED_CHOP);
  // R3 on-the-fly chop
  wire  otf_chop_w = (mode_ff == BL_ON_THE_FLY) & ~pin_ff.addr[CHOP_SELECT_BIT];
  wire  chop_w = fixed_chop_w | otf_chop_w;

  // R7 one bank or all banks
  wire  [7:0] bank_sel_w = 8'h01 << pin_ff.ba;
  wire  [7:0] pre_mask_w = pin_ff.addr[PRECHARGE_ALL_BIT] ? 8'hFF : bank_sel_w;

  // bank state, open on activate, idle after precharge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bank_open_o <= BANKS_RST;
    end else if (is_pre_w) begin
      // R8 precharged bank idle
      bank_open_o <= bank_open_o & ~pre_mask_w;
    end else if (is_act_w) begin
      bank_open_o <= bank_open_o | bank_sel_w;
    end
  end

  // access to an idle bank is a sticky fault for software to see
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      idle_access_err_o <= 1'b0;
      burst_chop_o <= 1'b0;
    end else if (is_rw_w) begin
      // R8 read or write to idle bank
      idle_access_err_o <= idle_access_err_o | ~|(bank_open_o & bank_sel_w);
      burst_chop_o <= chop_w;
    end
  end

  // self-refresh next state
  always_comb begin
    nxt_sr = sr_ff;
    case (sr_ff)
      SR_RUN: begin
        if (sr_entry_w) nxt_sr = SR_HOLD;
      end
      SR_HOLD: begin
        // R14 held while enable low
        if (sr_exit_w) nxt_sr = SR_EXIT;
      end
      SR_EXIT: begin
        // re-entry allowed once the short exit delay is done
        if (sr_entry_w) nxt_sr = SR_HOLD;
        else if (dll_ready_o) nxt_sr = SR_RUN;
      end
      default: nxt_sr = SR_RUN;
    endcase
  end

  // self-refresh state, loop control and the internal refresh
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sr_ff <= SR_RUN;
      dll_enable_o <= 1'b1;
      dll_reset_o <= 1'b0;
      internal_refresh_o <= 1'b0;
      self_refresh_o <= 1'b0;
    end else begin
      sr_ff <= nxt_sr;
      self_refresh_o <= (nxt_sr == SR_HOLD);
      // R10 loop off in, reset out
      dll_enable_o <= (nxt_sr != SR_HOLD);
      dll_reset_o <= sr_exit_w;
      // R15 refresh at entry, well inside the minimum enable pulse
      internal_refresh_o <= sr_entry_w;
    end
  end

  // exit delays on link clock edges; the counter saturates at the longer one
  // R20 counted from the exit edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || sr_ff != SR_EXIT) begin
      exit_cnt_ff <= EXIT_CNT_RST;
    end else if (ck_rise_w && !dll_ready_o) begin
      exit_cnt_ff <= exit_cnt_ff + 10'h001;
    end
  end

  // ready flags: the loop flag also stands in normal running
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      exit_ready_o <= 1'b1;
      dll_ready_o <= 1'b1;
    end else begin
      exit_ready_o <= (nxt_sr == SR_RUN) ||
                      (sr_ff == SR_EXIT && exit_cnt_ff >= SELF_REFRESH_EXIT_CYCLES);
      dll_ready_o <= (nxt_sr == SR_RUN) ||
                     (sr_ff == SR_EXIT && exit_cnt_ff >= LOCKED_LOOP_EXIT_CYCLES);
    end
  end

  // write capture: arm on the command, skip the preamble falling edge,
  // then take one beat per strobe crossing
  // R4 strobe crossings
  wire  start_w = wr_armed_ff & strobe_rise_w;
  wire  capture_w = start_w | ((beats_left_ff != BEATS_RST) & strobe_edge_w);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_armed_ff <= 1'b0;
      beats_left_ff <= BEATS_RST;
    end else if (is_wr_w) begin
      wr_armed_ff <= 1'b1;
      beats_left_ff <= BEATS_RST;
    end else if (start_w) begin
      wr_armed_ff <= 1'b0;
      beats_left_ff <= (burst_chop_o ? CHOP_BEATS : FULL_BEATS) - 4'h1;
    end else if (capture_w) begin
      beats_left_ff <= beats_left_ff - 4'h1;
    end
  end

  // the pins cannot be stalled, so a full fifo is reported as a sticky overrun
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_overrun_o <= 1'b0;
    end else begin
      wr_overrun_o <= wr_overrun_o | (capture_w & ~fifo_ready);
    end
  end

  beat_fifo #(.WIDTH($bits(wr_beat_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (pin_ff.beat),
    .in_valid_i  (capture_w),
    .in_ready_o  (fifo_ready),
    .out_data_o  (beat_o),
    .out_valid_o (beat_valid_o),
    .out_ready_i (beat_ready_i)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chop_fixed_a: assert property (is_rw_w && fixed_chop_w |=> burst_chop_o) // R2
    else $error("fixed chop mode did not chop");
  chop_otf_a: assert property (is_rw_w && mode_ff == BL_ON_THE_FLY |=> // R3
      burst_chop_o != $past(pin_ff.addr[CHOP_SELECT_BIT]))
    else $error("on-the-fly chop follows wrong bit");
  capture_edge_a: assert property (capture_w && !beat_valid_o // R4
      |=> beat_valid_o && beat_o == $past(pin_ff.beat))
    else $error("strobe beat not at fifo head");
  precharge_all_a: assert property (is_pre_w && pin_ff.addr[PRECHARGE_ALL_BIT] // R7
      |=> bank_open_o == 8'h00)
    else $error("precharge all left a bank open");
  bank_idle_a: assert property (is_pre_w && !pin_ff.addr[PRECHARGE_ALL_BIT] // R8
      |=> !bank_open_o[$past(pin_ff.ba)])
    else $error("precharged bank still open");
  entry_decode_a: assert property (sr_entry_w && sr_ff == SR_RUN // R9
      |=> self_refresh_o ##0 internal_refresh_o)
    else $error("self-refresh entry not taken");
  loop_off_a: assert property (self_refresh_o |-> !dll_enable_o) // R10
    else $error("loop enabled during self refresh");
  exit_reset_a: assert property (sr_exit_w |=> dll_reset_o ##1 !dll_reset_o // R20
      ##0 !exit_ready_o)
    else $error("exit edge did not reset loop");
  hold_ignore_a: assert property (sr_ff == SR_HOLD && !sr_exit_w // R14
      |=> $stable(bank_open_o) && self_refresh_o)
    else $error("command acted in self refresh");
endmodule

/* File: verif/ctrl_model.sv */
/*
  controller model: free-running command clock, command pins and write strobe.
  assumes the bench calls one task at a time and drives nothing else here.
*/
module ctrl_model
  import sdram_slice_pkg::*;
(
  output logic        cmd_clock_o,
  output logic        clock_enable_o,
  output logic        chip_select_n_o,
  output logic [2:0]  cmd_o,
  output logic [14:0] address_o,
  output logic [2:0]  bank_o,
  output logic        data_strobe_true_o,
  output wr_beat_s    beat_o
);
  timeunit 1ns;
  timeprecision 10ps;

  // idle pins; released strobe shows the inverse of its last low
  initial begin
    cmd_clock_o = 1'b0;
    clock_enable_o = 1'b1;
    chip_select_n_o = 1'b1;
    cmd_o = CMD_NOP;
    address_o = 15'h0000;
    bank_o = 3'h0;
    data_strobe_true_o = 1'b1;
    beat_o = '0;
  end

  always #62.5 cmd_clock_o = ~cmd_clock_o;

  task automatic cmd(input logic cke, input cmd_e c, input logic [14:0] a, input logic [2:0] b);
    @(negedge cmd_clock_o);
    clock_enable_o = cke;
    chip_select_n_o = 1'b0;
    cmd_o = c;
    address_o = a;
    bank_o = b;
    @(negedge cmd_clock_o);
    chip_select_n_o = 1'b1;
    cmd_o = ~c;
    address_o = ~a;
    bank_o = ~b;
  endtask

  task automatic set_cke(input logic v);
    @(negedge cmd_clock_o);
    clock_enable_o = v;
  endtask

  // one burst; data switches midway between strobe edges
  task automatic burst(input int n, input wr_beat_s b [8]);
    data_strobe_true_o = 1'b1;
    #125;
    data_strobe_true_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      #31.25;
      beat_o = b[i];
      #31.25;
      data_strobe_true_o = ~data_strobe_true_o;
    end
    #31.25;
    beat_o = ~beat_o;
    #31.25;
    data_strobe_true_o = 1'b1;
  endtask
endmodule

/* File: verif/tb_top.sv */
/*
  testbench: banks, burst chop, write capture and fifo, self refresh.
  assumes ctrl_model drives the pins and the package gives exit counts.
*/
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module tb_top
  import sdram_slice_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_i, sys_rst_i, beat_ready, stall;  // core clock, reset, consumer
  logic [1:0] burst_mode;                         // burst field under test
  wire cmd_clk, cke, cs_n, dqs;                   // pins from the model
  wire [2:0] cmd, ba;
  wire [14:0] addr;
  wire wr_beat_s pin_beat;
  logic [7:0] bank_open_o;
  logic burst_chop_o, self_refresh_o, dll_enable_o, dll_reset_o, internal_refresh_o;
  logic exit_ready_o, dll_ready_o, idle_access_err_o, wr_overrun_o, beat_valid_o;
  wr_beat_s beat_o;
  int bad_count, checked, cycles, ir_cnt, dr_cnt;
  int seed = 32'h818a;                            // fixed seed
  wr_beat_s exp_q[$];                             // expected beats in order
  wr_beat_s bb[8];

  ctrl_model i_ctrl_model (.cmd_clock_o(cmd_clk), .clock_enable_o(cke),
    .chip_select_n_o(cs_n), .cmd_o(cmd), .address_o(addr), .bank_o(ba),
    .data_strobe_true_o(dqs), .beat_o(pin_beat));

  sdram_slice i_sdram_slice (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .cmd_clock_i(cmd_clk), .clock_enable_i(cke), .chip_select_n_i(cs_n),
    .row_strobe_n_i(cmd[2]), .col_strobe_n_i(cmd[1]), .write_enable_n_i(cmd[0]),
    .address_i(addr), .bank_i(ba), .burst_mode_i(burst_mode),
    .data_strobe_true_i(dqs), .data_i(pin_beat.data), .data_mask_i(pin_beat.mask),
    .beat_ready_i(beat_ready), .bank_open_o(bank_open_o), .burst_chop_o(burst_chop_o),
    .self_refresh_o(self_refresh_o), .dll_enable_o(dll_enable_o),
    .dll_reset_o(dll_reset_o), .internal_refresh_o(internal_refresh_o),
    .exit_ready_o(exit_ready_o), .dll_ready_o(dll_ready_o),
    .idle_access_err_o(idle_access_err_o), .wr_overrun_o(wr_overrun_o),
    .beat_o(beat_o), .beat_valid_o(beat_valid_o));

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // core clock
  always #5 ref_clk_i = ~ref_clk_i;

  // hang guard; whole run is well under 10000 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // consumer stalls about one cycle in four
  always @(posedge ref_clk_i) begin
    #1;
    beat_ready = !stall && (($random(seed) & 3) != 0);
  end

  // pulse counters and in-order beat compare
  always @(posedge ref_clk_i) begin
    if (internal_refresh_o === 1'b1) ir_cnt++;
    if (dll_reset_o === 1'b1) dr_cnt++;
    if (beat_valid_o === 1'b1 && beat_ready === 1'b1) begin
      if (exp_q.size() == 0) `CHK("extra beat", 0, 1);
      else `CHK("beat", exp_q.pop_front(), beat_o);
    end
  end

  function automatic logic [14:0] rnd_addr(input logic a10, input logic a12);
    logic [14:0] r;
    r = 15'($random(seed));
    r[PRECHARGE_ALL_BIT] = a10;
    r[CHOP_SELECT_BIT] = a12;
    return r;
  endfunction

  // one command, then wait past the decode latency
  task automatic do_cmd(input logic k, input cmd_e c, input logic [14:0] a, input logic [2:0] b);
    i_ctrl_model.cmd(k, c, a, b);
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  // write burst; only the first keep beats fit when the consumer is stalled
  task automatic do_write(input logic a12, input int keep);
    logic c;
    int n;
    c = (burst_mode == BL_FIXED_CHOP) || (burst_mode == BL_ON_THE_FLY && !a12);
    n = c ? 4 : 8;
    for (int i = 0; i < 8; i++) bb[i] = {$random(seed), 4'($random(seed))};
    for (int i = 0; i < n && i < keep; i++) exp_q.push_back(bb[i]);
    i_ctrl_model.cmd(1'b1, CMD_WRITE, rnd_addr(1'b0, a12), 3'h5);
    i_ctrl_model.burst(n, bb);
    `CHK("write chop", c, burst_chop_o);
    repeat (40) @(posedge ref_clk_i);
    #1;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    burst_mode = BL_FIXED_FULL;
    stall = 1'b0;
    beat_ready = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK("reset", 16'h0038, {bank_open_o, burst_chop_o, self_refresh_o, dll_enable_o,
      exit_ready_o, dll_ready_o, idle_access_err_o, wr_overrun_o, beat_valid_o});
    for (int i = 0; i < 8; i++) do_cmd(1'b1, CMD_ACTIVATE, rnd_addr(1'b0, 1'b0), 3'(i));
    `CHK("all open", 8'hFF, bank_open_o);
    do_cmd(1'b1, CMD_PRECHARGE, rnd_addr(1'b0, 1'b0), 3'h3);
    `CHK("one closed", 8'hF7, bank_open_o);
    do_cmd(1'b1, CMD_PRECHARGE, rnd_addr(1'b1, 1'b0), 3'($random(seed)));
    `CHK("all closed", 8'h00, bank_open_o);
    do_cmd(1'b1, CMD_ACTIVATE, rnd_addr(1'b0, 1'b0), 3'h5);
    for (int m = 0; m < 3; m++) begin
      for (int a = 0; a < 2; a++) begin
        burst_mode = 2'(m);
        repeat (5) @(posedge ref_clk_i);
        #1;
        do_write(a[0], 8);
        do_cmd(1'b1, CMD_READ, rnd_addr(1'b0, !a[0]), 3'h5);
        `CHK("read chop", m == 2 || (m == 1 && a == 1), burst_chop_o);
      end
    end
    `CHK("no overrun", 1'b0, wr_overrun_o);
    burst_mode = BL_FIXED_FULL;
    stall = 1'b1;
    do_write(1'b1, 4);
    `CHK("overrun", 1'b1, wr_overrun_o);
    stall = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    #1;
    `CHK("beats left", 0, exp_q.size());
    `CHK("no idle err", 1'b0, idle_access_err_o);
    do_cmd(1'b1, CMD_READ, rnd_addr(1'b0, 1'b1), 3'h2);
    `CHK("idle err", 1'b1, idle_access_err_o);
    do_cmd(1'b1, CMD_PRECHARGE, rnd_addr(1'b1, 1'b0), 3'h0);
    do_cmd(1'b0, CMD_REFRESH, rnd_addr(1'b0, 1'b0), 3'h0);
    `CHK("sr entry", 3'b101, {self_refresh_o, dll_enable_o, ir_cnt == 1});
    // clock enable held low, command ignored
    do_cmd(1'b0, CMD_ACTIVATE, rnd_addr(1'b0, 1'b0), 3'h1);
    `CHK("sr hold", 9'h100, {self_refresh_o, bank_open_o});
    i_ctrl_model.set_cke(1'b1);
    @(posedge cmd_clk);
    // exit delays counted in clock rises
    repeat (15) @(posedge cmd_clk);
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("exiting", 4'b0011, {exit_ready_o, self_refresh_o, dll_enable_o, dr_cnt == 1});
    repeat (1) @(posedge cmd_clk);
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("exit delay", 2'b10, {exit_ready_o, dll_ready_o});
    i_ctrl_model.cmd(1'b1, CMD_CALIBRATE, rnd_addr(1'b1, 1'b0), 3'h0);
    repeat (494) @(posedge cmd_clk);
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("loop waiting", 1'b0, dll_ready_o);
    repeat (1) @(posedge cmd_clk);
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("loop ready", 1'b1, dll_ready_o);
    do_cmd(1'b1, CMD_ACTIVATE, rnd_addr(1'b0, 1'b0), 3'h1);
    `CHK("live again", 8'h02, bank_open_o);
    end_of_test();
  end
endmodule
